// File: rtl/lcc_decoder.sv
// Purpose: Command interpreter of a graphics LCD controller
// Assumes: Host strobes are synchronous to clk_i
// Notes: Display memory is written through a one-cycle strobe port
`timescale 1ns/1ps
module lcc_decoder #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic cmd_sel_i,
    input wire logic [7:0] wdata_i,
    input wire logic [15:0] line_pitch_i,
    output logic display_on_o,
    output logic [1:0] cursor_flash_field_o,
    output logic [1:0] block_one_attr_o,
    output logic [1:0] block_two_four_attr_o,
    output logic [1:0] block_three_attr_o,
    output logic [3:0] cursor_width_field_o,
    output logic [3:0] cursor_height_field_o,
    output logic cursor_block_select_o,
    output logic [1:0] shift_dir_o,
    output logic [ADDR_W-1:0] cursor_addr_o,
    output logic mem_we_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [7:0] mem_data_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_DISP, ST_LOAD, ST_SHAPE, ST_MEMORY_WRITE_CMD
    } lcc_state_t;

    lcc_state_t state_r;
    logic [3:0] param_idx_r;
    logic [7:0] display_enable_ctrl_r;
    logic [7:0] block_attribute_ctrl_r;
    logic [7:0] cursor_width_cfg_r;
    logic [7:0] cursor_height_style_cfg_r;
    logic [7:0] cursor_shift_dir_cfg_r;
    logic [7:0] cursor_addr_low_r;
    logic [7:0] cursor_addr_high_r;
    logic [ADDR_W-1:0] cursor_nxt;
    logic cmd_wr;
    logic data_wr;
    logic first_slot;
    logic second_slot;
    logic memory_write_cmd_byte;
    logic [ADDR_W-1:0] cursor_cur;

    assign cmd_wr = wr_i & cmd_sel_i;
    assign data_wr = wr_i & ~cmd_sel_i;

    // Slot decode shared by every parameter register
    assign first_slot = data_wr && param_idx_r == 4'h0;
    assign second_slot = data_wr && param_idx_r == 4'h1;

    // One stored byte per data strobe while streaming
    assign memory_write_cmd_byte = data_wr && state_r == ST_MEMORY_WRITE_CMD;

    // Cursor pair as one address, cast so the width stays explicit
    assign cursor_cur = ADDR_W'({cursor_addr_high_r, cursor_addr_low_r});

    // Address step after each stored byte
    function automatic logic [ADDR_W-1:0] step_addr(
        input logic [ADDR_W-1:0] addr,
        input logic [1:0] dir,
        input logic [15:0] pitch
    );
        logic [ADDR_W-1:0] step;
        // Down moves a whole line, any other heading one byte
        if (dir == lcc_pkg::DIR_DOWN)
            step = ADDR_W'(pitch);
        else
            step = ADDR_W'(1);
        return addr + step;
    endfunction

    // Pitch is read live: change it only between write streams
    assign cursor_nxt = step_addr(
        cursor_cur, shift_dir_o,
        line_pitch_i);

    // Sequencer: a code opens a frame, data bytes fill its slots
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= ST_IDLE;
            param_idx_r <= 4'h0;
        end
        else if (cmd_wr)
        begin
            param_idx_r <= 4'h0;
            case (wdata_i)
                lcc_pkg::CMD_DISP_OFF: state_r <= ST_DISP;
                lcc_pkg::CMD_DISP_ON: state_r <= ST_DISP;
                lcc_pkg::CMD_CURSOR_LOAD: state_r <= ST_LOAD;
                lcc_pkg::CMD_CURSOR_SHAPE: state_r <= ST_SHAPE;
                lcc_pkg::CMD_MEM_WRITE: state_r <= ST_MEMORY_WRITE_CMD;
                default: state_r <= ST_IDLE;
            endcase
        end
        else if (data_wr && param_idx_r != 4'hF)
        begin
            // Saturate so long streams never wrap into slot zero
            param_idx_r <= param_idx_r + 4'h1;
        end
    end

    // Display enable and block attributes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            display_enable_ctrl_r <= lcc_pkg::RST_BYTE;
            block_attribute_ctrl_r <= lcc_pkg::RST_BYTE;
        end
        else if (cmd_wr && wdata_i == lcc_pkg::CMD_DISP_OFF)
            display_enable_ctrl_r[lcc_pkg::DISP_EN_BIT] <= 1'b0;
        else if (cmd_wr && wdata_i == lcc_pkg::CMD_DISP_ON)
            display_enable_ctrl_r[lcc_pkg::DISP_EN_BIT] <= 1'b1;
        // Parameter slot taken after either display code
        else if (first_slot && state_r == ST_DISP)
            block_attribute_ctrl_r <= wdata_i;
    end

    // Cursor shape
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cursor_width_cfg_r <= lcc_pkg::RST_BYTE;
            cursor_height_style_cfg_r <= lcc_pkg::RST_BYTE;
        end
        else if (data_wr && state_r == ST_SHAPE)
        begin
            if (first_slot)
                cursor_width_cfg_r <= wdata_i;
            else if (second_slot)
                cursor_height_style_cfg_r <= wdata_i;
        end
    end

    // Heading family: code low bits carry the direction
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cursor_shift_dir_cfg_r <= lcc_pkg::RST_BYTE;
        else if (cmd_wr && (wdata_i & lcc_pkg::CMD_HEADING_MASK) ==
                 lcc_pkg::CMD_HEADING_BASE)
            cursor_shift_dir_cfg_r <= {6'h00, wdata_i[1:0]};
    end

    // Cursor address: loaded by parameters, stepped by writes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cursor_addr_low_r <= lcc_pkg::RST_BYTE;
            cursor_addr_high_r <= lcc_pkg::RST_BYTE;
        end
        else if (data_wr && state_r == ST_LOAD)
        begin
            if (first_slot)
                cursor_addr_low_r <= wdata_i;
            else if (second_slot)
                cursor_addr_high_r <= wdata_i;
        end
        // Streaming steps the cursor as the byte is stored
        else if (memory_write_cmd_byte)
        begin
            cursor_addr_low_r <= cursor_nxt[7:0];
            cursor_addr_high_r <= cursor_nxt[15:8];
        end
    end

    // Memory write strobe, one cycle per byte
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mem_we_o <= 1'b0;
            mem_addr_o <= '0;
            mem_data_o <= lcc_pkg::RST_BYTE;
        end
        else
        begin
            mem_we_o <= memory_write_cmd_byte;
            if (memory_write_cmd_byte)
            begin
                // Address before the step; the cursor moves on in parallel
                mem_addr_o <= cursor_cur;
                mem_data_o <= wdata_i;
            end
        end
    end

    // Host is trusted to blank first; no ordering is enforced
    assign display_on_o = display_enable_ctrl_r[lcc_pkg::DISP_EN_BIT];
    assign cursor_flash_field_o = block_attribute_ctrl_r[1:0];
    assign block_one_attr_o = block_attribute_ctrl_r[3:2];
    assign block_two_four_attr_o = block_attribute_ctrl_r[5:4];
    assign block_three_attr_o = block_attribute_ctrl_r[7:6];
    assign cursor_width_field_o = cursor_width_cfg_r[3:0];
    assign cursor_height_field_o = cursor_height_style_cfg_r[3:0];
    assign cursor_block_select_o =
        cursor_height_style_cfg_r[lcc_pkg::BLOCK_SEL_BIT];
    assign shift_dir_o = cursor_shift_dir_cfg_r[1:0];
    assign cursor_addr_o = cursor_cur;
endmodule

// File: rtl/lcc_pkg.sv
// Purpose: Constants for the LCD command decoder
// Assumes: 8-bit host bus, command/data port select
// Notes: Register indices are the controller's internal slots
package lcc_pkg;
    // Command codes
    localparam logic [7:0] CMD_DISP_OFF = 8'h58;
    localparam logic [7:0] CMD_DISP_ON = 8'h59;
    localparam logic [7:0] CMD_CURSOR_LOAD = 8'h46;
    localparam logic [7:0] CMD_CURSOR_SHAPE = 8'h5D;
    localparam logic [7:0] CMD_HEADING_BASE = 8'h4C;
    localparam logic [7:0] CMD_MEM_WRITE = 8'h42;
    localparam logic [7:0] CMD_HEADING_MASK = 8'hFC;
    // Register slots
    localparam logic [7:0] REG_LINE_PITCH_LO = 8'h06;
    localparam logic [7:0] REG_LINE_PITCH_HI = 8'h07;
    localparam logic [7:0] REG_DISPLAY_ENABLE = 8'h09;
    localparam logic [7:0] REG_BLOCK_ATTR = 8'h0A;
    localparam logic [7:0] REG_CURSOR_WIDTH = 8'h15;
    localparam logic [7:0] REG_CURSOR_HEIGHT = 8'h16;
    localparam logic [7:0] REG_SHIFT_DIR = 8'h17;
    localparam logic [7:0] REG_CURSOR_LO = 8'h1C;
    localparam logic [7:0] REG_CURSOR_HI = 8'h1D;
    // Field positions
    localparam int DISP_EN_BIT = 0;
    localparam int BLOCK_SEL_BIT = 7;
    // Shift directions, bits 1-0 of the direction register
    localparam logic [1:0] DIR_RIGHT = 2'h0;
    localparam logic [1:0] DIR_DOWN = 2'h3;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_PITCH = 16'h0080;
endpackage

// File: test/lcc_chk.sv
// Purpose: Port checker for the LCD command decoder
// Assumes: One host byte per clock at most
// Notes: Bound to every decoder instance
`timescale 1ns/1ps
module lcc_chk #(
    parameter int ADDR_W = 16
) (
    input logic clk_i,
    input logic rst_n_i,
    input logic wr_i,
    input logic cmd_sel_i,
    input logic [7:0] wdata_i,
    input logic [15:0] line_pitch_i,
    input logic display_on_o,
    input logic [1:0] cursor_flash_field_o,
    input logic [1:0] block_one_attr_o,
    input logic [1:0] block_two_four_attr_o,
    input logic [1:0] block_three_attr_o,
    input logic [3:0] cursor_width_field_o,
    input logic [3:0] cursor_height_field_o,
    input logic cursor_block_select_o,
    input logic [1:0] shift_dir_o,
    input logic [ADDR_W-1:0] cursor_addr_o,
    input logic mem_we_o,
    input logic [ADDR_W-1:0] mem_addr_o,
    input logic [7:0] mem_data_o
);
    // Code and parameter strobes
    logic cw;
    logic dw;
    assign cw = wr_i && cmd_sel_i;
    assign dw = wr_i && !cmd_sel_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_off; cw && wdata_i == 8'h58 |=> !display_on_o; endproperty
    a_off: assert property (p_off) else $error("blank failed");
    property p_on; cw && wdata_i == 8'h59 |=> display_on_o; endproperty
    a_on: assert property (p_on) else $error("enable failed");
    property p_attr;
        cw && wdata_i[7:1] == 7'h2C ##1 dw |=>
            {block_three_attr_o, block_two_four_attr_o, block_one_attr_o,
            cursor_flash_field_o} == $past(wdata_i);
    endproperty
    a_attr: assert property (p_attr) else $error("attr bad");
    property p_load; cw && wdata_i == 8'h46 ##1 dw ##1 dw |=>
        cursor_addr_o == {$past(wdata_i), $past(wdata_i, 2)}; endproperty
    a_load: assert property (p_load) else $error("load bad");
    property p_shape;
        cw && wdata_i == 8'h5D ##1 dw ##1 dw |=>
            cursor_width_field_o == $past(wdata_i[3:0], 2) &&
            {cursor_block_select_o, cursor_height_field_o} ==
            $past({wdata_i[7], wdata_i[3:0]});
    endproperty
    a_shape: assert property (p_shape) else $error("shape");
    property p_dir; cw && wdata_i[7:2] == 6'h13 |=>
        shift_dir_o == $past(wdata_i[1:0]); endproperty
    a_dir: assert property (p_dir) else $error("heading bad");
    property p_data; mem_we_o |-> $past(dw) && mem_data_o == $past(wdata_i);
    endproperty
    a_data: assert property (p_data) else $error("mem write bad");
    property p_step; mem_we_o |-> cursor_addr_o == mem_addr_o +
        (shift_dir_o == 2'h3 ? line_pitch_i : 16'h0001); endproperty
    a_step: assert property (p_step) else $error("step");
    // Codes 70h-7Fh are not decoded, so their data must not store
    property p_refuse; cw && wdata_i[7:4] == 4'h7 ##1 dw |=> !mem_we_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused");
endmodule
bind lcc_decoder lcc_chk #(.ADDR_W(ADDR_W)) lcc_chk_inst (.*);

// File: test/lcc_decoder_test.sv
// Purpose: Self-checking bench of the LCD command decoder
// Assumes: 20 MHz clock, host model drives the bytes
// Notes: Line pitch 128 addresses, narrowed in the last scenario
`timescale 1ns/1ps
module lcc_decoder_test;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr, cs, dsp, blk, we;
    logic [7:0] wd, md;
    logic [1:0] fl, b1, b24, b3, dir;
    logic [3:0] cwd, cht;
    logic [15:0] ca, ma;
    logic [15:0] pitch = 16'h0080;
    int fail_count = 0;
    int total_checks = 0;
    lcc_host lcc_host_inst (.clk_i(clk_i), .wr_o(wr), .cmd_sel_o(cs),
        .wdata_o(wd));
    lcc_decoder lcc_decoder_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .wr_i(wr), .cmd_sel_i(cs), .wdata_i(wd), .line_pitch_i(pitch),
        .display_on_o(dsp), .cursor_flash_field_o(fl), .block_one_attr_o(b1),
        .block_two_four_attr_o(b24), .block_three_attr_o(b3),
        .cursor_width_field_o(cwd), .cursor_height_field_o(cht),
        .cursor_block_select_o(blk), .shift_dir_o(dir), .cursor_addr_o(ca),
        .mem_we_o(we), .mem_addr_o(ma), .mem_data_o(md));
    // 50 ns period
    initial forever #25 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic p(input logic c, input logic [7:0] d);
        lcc_host_inst.put(c, d);
    endtask
    // Enable first so blanking is seen, store two bytes, enable
    task automatic t_display();
        p(1'b1, 8'h59);
        lcc_host_inst.idle();
        chk(dsp, 1'b1);
        p(1'b1, 8'h58);
        p(1'b0, 8'h56);
        lcc_host_inst.idle();
        chk(dsp, 1'b0);
        chk({b3, b24, b1, fl}, 8'h56);
        p(1'b1, 8'h42);
        p(1'b0, 8'h20);
        p(1'b0, 8'h00);
        p(1'b1, 8'h59);
        p(1'b0, 8'h16);
        lcc_host_inst.idle();
        chk(dsp, 1'b1);
        chk({b3, b24, b1, fl}, 8'h16);
        chk(ca, 16'h0002);
    endtask
    // Extra parameter must not wrap to the first slot
    task automatic t_shape();
        p(1'b1, 8'h5D);
        p(1'b0, 8'h04);
        p(1'b0, 8'h86);
        p(1'b0, 8'h0F);
        lcc_host_inst.idle();
        chk(cwd, 4'h4);
        chk({blk, cht}, 5'h16);
    endtask
    // Down then right, bytes back to back
    task automatic t_stream();
        p(1'b1, 8'h46);
        p(1'b0, 8'h01);
        p(1'b0, 8'h10);
        p(1'b1, 8'h4F);
        lcc_host_inst.idle();
        chk(ca, 16'h1001);
        chk(dir, 2'h3);
        p(1'b1, 8'h42);
        repeat (3) p(1'b0, 8'hFF);
        lcc_host_inst.idle();
        chk({we, md, ma}, 25'h1FF1101);
        chk(ca, 16'h1181);
        p(1'b1, 8'h4C);
        p(1'b1, 8'h42);
        p(1'b0, 8'h45);
        p(1'b0, 8'h50);
        lcc_host_inst.idle();
        chk({ma, ca}, 32'h11821183);
    endtask
    // Unknown code: following byte dropped
    task automatic t_refuse();
        p(1'b1, 8'h70);
        p(1'b0, 8'h33);
        lcc_host_inst.idle();
        chk({we, ca}, 17'h01183);
    endtask
    // Narrower line: down steps must follow the pitch input
    task automatic t_pitch();
        pitch = 16'h0028;
        p(1'b1, 8'h4F);
        p(1'b1, 8'h46);
        p(1'b0, 8'h00);
        p(1'b0, 8'h00);
        p(1'b1, 8'h42);
        p(1'b0, 8'hAA);
        p(1'b0, 8'h55);
        lcc_host_inst.idle();
        chk({ma, ca}, 32'h00280050);
        chk({we, md}, 9'h155);
    endtask
    initial
    begin
        #1000000;
        fail_count++;
        print_verdict();
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i) rst_n_i = 1'b1;
        t_display();
        t_shape();
        t_stream();
        t_refuse();
        t_pitch();
        print_verdict();
    end
endmodule

// File: test/lcc_host.sv
// Purpose: Host processor model writing command and data bytes
// Assumes: Bytes driven at the falling edge
// Notes: Released data lines invert so stale bytes never match
`timescale 1ns/1ps
module lcc_host (
    input wire logic clk_i,
    output logic wr_o,
    output logic cmd_sel_o,
    output logic [7:0] wdata_o
);
    initial {wr_o, cmd_sel_o, wdata_o} = 10'h000;
    // Code on the command port, parameters on the data port
    task automatic put(input logic c, input logic [7:0] d);
        @(negedge clk_i);
        wr_o = 1'b1;
        cmd_sel_o = c;
        wdata_o = d;
    endtask
    // Release the bus
    task automatic idle();
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~wdata_o;
    endtask
endmodule
